/* design/tsr_cfg.svh */
// constants for the temperature sensor register port
// What this block does
// RQ1: address, pointer byte, then one data byte
// RQ2: limit registers take MSB and LSB together
// RQ3: surplus write bytes are dropped silently
// RQ4: new register needs new start and pointer
// RQ5: one-byte and two-byte reads, MSB first
// RQ6: master sets pointer before reading
// RQ7: pointer steps MSB to LSB on reads
// RQ8: no pointer increment across registers
// RQ9: pointer kept between transactions
// RQ10: master acks MSB, nacks final byte
// RQ11: pointer byte 0x2f reloads all defaults
// RQ12: no acknowledge during default reload
// RQ13: master waits reload time after reset
// RQ14: acknowledge general call and its command
// RQ15: general call 0x06 performs full reset
// RQ16: other general call commands not acknowledged
// RQ17: alert starts in interrupt mode
// RQ18: alert on high or low excursion
// RQ19: comparator release uses hysteresis thresholds
// RQ20: comparator alert survives shutdown
// RQ21: interrupt alert cleared by any read
// RQ22: interrupt alert cleared by shutdown
// RQ23: slave address 10010 plus two pins
// RQ24: hysteresis subtracted high, added low
`ifndef TSR_CFG_SVH
`define TSR_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define TSR_OFF_TEMP_MSB 8'h00
`define TSR_OFF_TEMP_LSB 8'h01
`define TSR_OFF_STATUS 8'h02
`define TSR_OFF_CFG 8'h03
`define TSR_OFF_HIGH_MSB 8'h04
`define TSR_OFF_HIGH_LSB 8'h05
`define TSR_OFF_LOW_MSB 8'h06
`define TSR_OFF_LOW_LSB 8'h07
`define TSR_OFF_CRIT_MSB 8'h08
`define TSR_OFF_CRIT_LSB 8'h09
`define TSR_OFF_HYST 8'h0a
`define TSR_OFF_ID 8'h0b
// ----------------------------------------
// commands and addresses
// ----------------------------------------
`define TSR_CMD_SOFT_RESET 8'h2f
`define TSR_GC_RESET 8'h06
`define TSR_GC_ADDR 8'h00
`define TSR_ADDR_FIXED 5'h12
// ----------------------------------------
// reset values
// ----------------------------------------
`define TSR_RST_CFG 8'h00
`define TSR_RST_HIGH 16'h2000
`define TSR_RST_LOW 16'h0500
`define TSR_RST_CRIT 16'h4980
`define TSR_RST_HYST 8'h05
// identification value is arbitrary
`define TSR_RST_ID 8'h5a
// ----------------------------------------
// field positions
// ----------------------------------------
`define TSR_CFG_MODE_BIT 4
`define TSR_CFG_SHDN_HI 6
`define TSR_CFG_SHDN_LO 5
`define TSR_SHDN_CODE 2'h3
`define TSR_ST_HIGH_BIT 6
`define TSR_ST_LOW_BIT 5
`define TSR_ST_ALERT_BIT 4
`define TSR_HYST_SHIFT 7
// ----------------------------------------
// timing
// ----------------------------------------
`define TSR_CLK_NS 100
`define TSR_RELOAD_NS 200000
`define TSR_RELOAD_CYC ((`TSR_RELOAD_NS + `TSR_CLK_NS - 1) / `TSR_CLK_NS)
`define TSR_SCL_NS 10000
`define TSR_SCL_QTR_CYC (`TSR_SCL_NS / 4 / `TSR_CLK_NS)
`endif

/* design/tsr_pkg.sv */
// types shared by both ends of the sensor port
package tsr_pkg;
  // device link state, one-hot
  typedef enum logic [5:0] {
    TSR_D_IDLE = 6'h01,
    TSR_D_RX = 6'h02,
    TSR_D_ACK = 6'h04,
    TSR_D_TX = 6'h08,
    TSR_D_RACK = 6'h10,
    TSR_D_WAIT = 6'h20
  } tsr_dev_st_t;
  // host sequencer state, one-hot
  typedef enum logic [3:0] {
    TSR_H_IDLE = 4'h1,
    TSR_H_START = 4'h2,
    TSR_H_BIT = 4'h4,
    TSR_H_STOP = 4'h8
  } tsr_host_st_t;
endpackage

/* design/tsr_link_if.sv */
// two-wire link between master and sensor port
`timescale 1ns/1ps
interface tsr_link_if;
  // master drives clock and data
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  // sensor drives data only
  logic sda_dev_o;
  logic sda_dev_oe;
  // wired-and line levels, pulled up when idle
  logic scl;
  logic sda;
  assign scl = scl_host_oe ? scl_host_o : 1'b1;
  assign sda = (sda_host_oe ? sda_host_o : 1'b1) & (sda_dev_oe ? sda_dev_o : 1'b1);
  modport host (output scl_host_o, output scl_host_oe, output sda_host_o, output sda_host_oe,
                input scl, input sda);
  modport device (output sda_dev_o, output sda_dev_oe, input scl, input sda);
endinterface

/* design/tsr_device.sv */
// sensor end: two-wire slave, register file and alert logic
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module tsr_device (
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // link
  tsr_link_if.device link,
  // address select pins
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  // measured temperature, same clock
  input wire logic [15:0] temp_value,
  // alert pin, open drain
  output logic alert_o,
  output logic alert_oe,
  // status
  output logic alert_active,
  output logic reload_busy
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_s1_q; // first stage: a1, a0, sda, scl
  logic [3:0] pin_s2_q; // second stage
  logic [1:0] pin_prev_q; // previous sda, scl for edges
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  // two flops before any logic looks at a pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_s1_q <= 4'h3;
      pin_s2_q <= 4'h3;
      pin_prev_q <= 2'h3;
    end else begin
      pin_s1_q <= {addr_select_bit1, addr_select_bit0, link.sda, link.scl};
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q[1:0];
    end
  end
  assign scl_rise = pin_s2_q[0] & ~pin_prev_q[0];
  assign scl_fall = ~pin_s2_q[0] & pin_prev_q[0];
  // data edges while clock stays high frame the transfer
  assign start_c = pin_s2_q[0] & pin_prev_q[0] & ~pin_s2_q[1] & pin_prev_q[1];
  assign stop_c = pin_s2_q[0] & pin_prev_q[0] & pin_s2_q[1] & ~pin_prev_q[1];

  // ----------------------------------------
  // link state
  // ----------------------------------------
  tsr_pkg::tsr_dev_st_t st_q; // link state
  logic [7:0] sh_q; // receive shift register
  logic [7:0] tx_q; // transmit shift register
  logic [3:0] cnt_q; // bit counter
  logic aph_q; // next byte is the address
  logic rw_q; // read transfer
  logic gc_q; // general call transfer
  logic [1:0] wcnt_q; // write index, or read half
  logic [7:0] ptr_q; // address pointer
  logic sda_oe_q; // pulling data low
  logic rst_pend_q; // reload on next stop
  logic [11:0] busy_q; // reload countdown
  logic byte_end; // eighth bit complete
  logic byte_ack; // acknowledge this byte
  logic addr_hit; // own address seen
  logic rd_clr; // read transfer accepted
  logic reload_go; // reload defaults now
  logic wr_en; // register write strobe
  logic [7:0] wr_addr; // register write target
  logic [7:0] rd_byte; // byte at pointer
  // register file
  logic [7:0] cfg_q;
  logic [15:0] high_q;
  logic [15:0] low_q;
  logic [15:0] crit_q;
  logic [7:0] hyst_q;
  logic [7:0] status;
  logic alert_q;
  logic exc_q;
  logic over;
  logic under;

  // pointer at the MSB of a two-byte register
  function automatic logic pair_msb(input logic [7:0] a);
    pair_msb = (a == `TSR_OFF_TEMP_MSB) || (a == `TSR_OFF_HIGH_MSB) ||
               (a == `TSR_OFF_LOW_MSB) || (a == `TSR_OFF_CRIT_MSB);
  endfunction

  assign byte_end = scl_fall && (st_q == tsr_pkg::TSR_D_RX) && (cnt_q == 4'h8);
  // RQ23: fixed upper bits, pins below
  assign addr_hit = (sh_q[7:1] == {`TSR_ADDR_FIXED, pin_s2_q[3], pin_s2_q[2]});

  // decide whether the byte just received is acknowledged
  always_comb begin
    byte_ack = 1'b1;
    if (aph_q) begin
      // RQ12: silent while reloading
      // RQ14: general call address accepted
      byte_ack = (busy_q == 12'h000) && (addr_hit || (sh_q == `TSR_GC_ADDR));
    end else if (gc_q) begin
      // RQ16: only the reset code
      byte_ack = (sh_q == `TSR_GC_RESET);
    end
  end

  // RQ21: any accepted read clears the interrupt
  assign rd_clr = byte_end && aph_q && byte_ack && sh_q[0];
  assign reload_go = stop_c && rst_pend_q;

  // RQ2: second byte lands in the LSB half
  // RQ3: other surplus bytes write nothing
  assign wr_en = byte_end && !aph_q && !gc_q &&
                 ((wcnt_q == 2'h1) || ((wcnt_q == 2'h2) && pair_msb(ptr_q) && (ptr_q != `TSR_OFF_TEMP_MSB)));
  assign wr_addr = (wcnt_q == 2'h1) ? ptr_q : ptr_q + 8'h01;

  // link state machine
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= tsr_pkg::TSR_D_IDLE;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      cnt_q <= 4'h0;
      aph_q <= 1'b0;
      rw_q <= 1'b0;
      gc_q <= 1'b0;
      wcnt_q <= 2'h0;
      ptr_q <= 8'h00;
      sda_oe_q <= 1'b0;
      rst_pend_q <= 1'b0;
    end else if (start_c) begin
      // start or repeated start opens a new address phase
      st_q <= tsr_pkg::TSR_D_RX;
      cnt_q <= 4'h0;
      aph_q <= 1'b1;
      wcnt_q <= 2'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_c) begin
      st_q <= tsr_pkg::TSR_D_IDLE;
      sda_oe_q <= 1'b0;
      rst_pend_q <= 1'b0;
      // pointer returns to its default with the reload
      if (rst_pend_q) begin
        ptr_q <= 8'h00;
      end
    end else begin
      case (st_q)
        tsr_pkg::TSR_D_RX: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], pin_s2_q[1]};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_end) begin
            // acknowledge by pulling data low for the ninth clock
            if (byte_ack) begin
              st_q <= tsr_pkg::TSR_D_ACK;
              sda_oe_q <= 1'b1;
            end else begin
              st_q <= tsr_pkg::TSR_D_WAIT;
            end
            if (aph_q) begin
              aph_q <= 1'b0;
              rw_q <= sh_q[0];
              gc_q <= (sh_q[7:1] == 7'h00);
            end else begin
              if (!gc_q && (wcnt_q != 2'h3)) begin
                wcnt_q <= wcnt_q + 2'h1;
              end
              // RQ1: first data byte is the pointer
              // RQ9: held until the next pointer write or reload
              if (!gc_q && (wcnt_q == 2'h0)) begin
                ptr_q <= sh_q;
              end
              // RQ11: pointer command arms a reload
              // RQ15: general call reset arms a reload
              if ((gc_q && byte_ack) || (!gc_q && (wcnt_q == 2'h0) && (sh_q == `TSR_CMD_SOFT_RESET))) begin
                rst_pend_q <= 1'b1;
              end
            end
          end
        end
        tsr_pkg::TSR_D_ACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              // RQ5: first byte out is the pointed register
              st_q <= tsr_pkg::TSR_D_TX;
              tx_q <= rd_byte;
              sda_oe_q <= ~rd_byte[7];
              cnt_q <= 4'h1;
            end else begin
              st_q <= tsr_pkg::TSR_D_RX;
              sda_oe_q <= 1'b0;
            end
          end
        end
        tsr_pkg::TSR_D_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              // release data for the master's answer
              st_q <= tsr_pkg::TSR_D_RACK;
              sda_oe_q <= 1'b0;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              sda_oe_q <= ~tx_q[6];
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        tsr_pkg::TSR_D_RACK: begin
          if (scl_rise) begin
            if (pin_s2_q[1]) begin
              // no acknowledge ends the readback
              st_q <= tsr_pkg::TSR_D_WAIT;
            end else begin
              cnt_q <= 4'h9;
              // RQ7: step from MSB to LSB
              // RQ8: otherwise the pointer stays put
              if (pair_msb(ptr_q)) begin
                wcnt_q <= 2'h1;
              end
            end
          end else if (scl_fall && (cnt_q == 4'h9)) begin
            st_q <= tsr_pkg::TSR_D_TX;
            tx_q <= rd_byte;
            sda_oe_q <= ~rd_byte[7];
            cnt_q <= 4'h1;
          end
        end
        tsr_pkg::TSR_D_IDLE, tsr_pkg::TSR_D_WAIT: begin
          // wait for the next start
          sda_oe_q <= 1'b0;
        end
        default: begin
          st_q <= tsr_pkg::TSR_D_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // RQ12: reload countdown blocks acknowledges
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_q <= 12'h000;
    end else if (reload_go) begin
      busy_q <= 12'(`TSR_RELOAD_CYC);
    end else if (busy_q != 12'h000) begin
      busy_q <= busy_q - 12'h001;
    end
  end

  // RQ11: writable registers return to defaults
  always_ff @(posedge clk_sys) begin
    if (rst || reload_go) begin
      cfg_q <= `TSR_RST_CFG;
      high_q <= `TSR_RST_HIGH;
      low_q <= `TSR_RST_LOW;
      crit_q <= `TSR_RST_CRIT;
      hyst_q <= `TSR_RST_HYST;
    end else if (wr_en) begin
      case (wr_addr)
        `TSR_OFF_CFG: cfg_q <= sh_q;
        `TSR_OFF_HIGH_MSB: high_q[15:8] <= sh_q;
        `TSR_OFF_HIGH_LSB: high_q[7:0] <= sh_q;
        `TSR_OFF_LOW_MSB: low_q[15:8] <= sh_q;
        `TSR_OFF_LOW_LSB: low_q[7:0] <= sh_q;
        `TSR_OFF_CRIT_MSB: crit_q[15:8] <= sh_q;
        `TSR_OFF_CRIT_LSB: crit_q[7:0] <= sh_q;
        `TSR_OFF_HYST: hyst_q <= sh_q;
        // read-only and unmapped offsets ignore writes
        default: begin
        end
      endcase
    end
  end

  assign status = 8'h00 | (8'(over) << `TSR_ST_HIGH_BIT) | (8'(under) << `TSR_ST_LOW_BIT) |
                  (8'(alert_q) << `TSR_ST_ALERT_BIT);

  // read multiplexer, unmapped offsets read zero
  always_comb begin
    case (ptr_q | {7'h00, wcnt_q[0]})
      `TSR_OFF_TEMP_MSB: rd_byte = temp_value[15:8];
      `TSR_OFF_TEMP_LSB: rd_byte = temp_value[7:0];
      `TSR_OFF_STATUS: rd_byte = status;
      `TSR_OFF_CFG: rd_byte = cfg_q;
      `TSR_OFF_HIGH_MSB: rd_byte = high_q[15:8];
      `TSR_OFF_HIGH_LSB: rd_byte = high_q[7:0];
      `TSR_OFF_LOW_MSB: rd_byte = low_q[15:8];
      `TSR_OFF_LOW_LSB: rd_byte = low_q[7:0];
      `TSR_OFF_CRIT_MSB: rd_byte = crit_q[15:8];
      `TSR_OFF_CRIT_LSB: rd_byte = crit_q[7:0];
      `TSR_OFF_HYST: rd_byte = hyst_q;
      `TSR_OFF_ID: rd_byte = `TSR_RST_ID;
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // alert logic
  // ----------------------------------------
  logic signed [16:0] t_s; // temperature, sign extended
  logic signed [16:0] hi_s; // high limit
  logic signed [16:0] lo_s; // low limit
  logic signed [16:0] hy_s; // hysteresis in temperature units
  logic shdn; // shutdown selected
  logic cmp_mode; // comparator mode selected
  assign t_s = {temp_value[15], temp_value};
  assign hi_s = {high_q[15], high_q};
  assign lo_s = {low_q[15], low_q};
  assign hy_s = 17'(hyst_q[3:0]) <<< `TSR_HYST_SHIFT;
  assign shdn = (cfg_q[`TSR_CFG_SHDN_HI:`TSR_CFG_SHDN_LO] == `TSR_SHDN_CODE);
  // RQ17: mode bit clear means interrupt mode
  assign cmp_mode = cfg_q[`TSR_CFG_MODE_BIT];
  // RQ18: strict excursion beyond either limit
  assign over = (t_s > hi_s);
  assign under = (t_s < lo_s);

  // alert state, set wins over a read clear, shutdown blocks set in interrupt mode only
  always_ff @(posedge clk_sys) begin
    if (rst || reload_go) begin
      alert_q <= 1'b0;
      exc_q <= 1'b0;
    end else begin
      exc_q <= over | under;
      if (cmp_mode) begin
        // RQ20: shutdown not consulted here
        if (over || under) begin
          alert_q <= 1'b1;
        // RQ19: release only beyond the hysteresis band
        // RQ24: minus on high, plus on low
        end else if ((t_s < hi_s - hy_s) && (t_s > lo_s + hy_s)) begin
          alert_q <= 1'b0;
        end
      end else begin
        // RQ21: only a fresh excursion sets it again
        if ((over || under) && !exc_q && !shdn) begin
          alert_q <= 1'b1;
        // RQ22: shutdown clears in interrupt mode
        end else if (rd_clr || shdn) begin
          alert_q <= 1'b0;
        end
      end
    end
  end

  // outputs
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe = sda_oe_q;
  assign alert_o = 1'b0;
  assign alert_oe = alert_q;
  assign alert_active = alert_q;
  assign reload_busy = (busy_q != 12'h000);
endmodule

/* design/tsr_host.sv */
// master end: runs one write or read transfer per request
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module tsr_host (
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // link
  tsr_link_if.host link,
  // request
  input wire logic req,
  input wire logic rd_not_wr,
  input wire logic [6:0] slave_addr,
  input wire logic [7:0] ptr_byte,
  input wire logic [1:0] wr_len,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] rd_len,
  // answer
  output logic busy,
  output logic done,
  output logic nacked,
  output logic [15:0] rd_data
);
  tsr_pkg::tsr_host_st_t st_q; // sequencer state
  logic [7:0] div_q; // quarter period divider
  logic tick; // one quarter of the link clock
  logic [1:0] q_q; // quarter within a bit
  logic [3:0] bit_q; // bit within a byte, 8 is ack
  logic [2:0] bi_q; // byte index
  logic [2:0] nb_q; // bytes in this transfer
  logic rw_q;
  logic [6:0] addr_q;
  logic [7:0] ptr_q;
  logic [15:0] wd_q;
  logic [7:0] rx_q; // receive shift
  logic scl_oe_q;
  logic sda_oe_q;
  logic done_q;
  logic nack_q;
  logic [15:0] rd_q;
  logic [1:0] sda_s_q; // data line synchroniser
  logic [7:0] tx_byte; // byte being sent
  logic tx_phase; // master sends this byte
  logic last; // final byte of the transfer

  // quarter period enable
  always_ff @(posedge clk_sys) begin
    if (rst || (div_q == 8'(`TSR_SCL_QTR_CYC - 1))) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign tick = (div_q == 8'(`TSR_SCL_QTR_CYC - 1));

  // data line synchroniser
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sda_s_q <= 2'h3;
    end else begin
      sda_s_q <= {sda_s_q[0], link.sda};
    end
  end

  always_comb begin
    case (bi_q)
      3'h0: tx_byte = {addr_q, rw_q};
      3'h1: tx_byte = ptr_q;
      3'h2: tx_byte = wd_q[15:8];
      default: tx_byte = wd_q[7:0];
    endcase
  end
  assign tx_phase = ~rw_q | (bi_q == 3'h0);
  assign last = (bi_q == nb_q - 3'h1);

  // transfer sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= tsr_pkg::TSR_H_IDLE;
      q_q <= 2'h0;
      bit_q <= 4'h0;
      bi_q <= 3'h0;
      nb_q <= 3'h1;
      rw_q <= 1'b0;
      addr_q <= 7'h00;
      ptr_q <= 8'h00;
      wd_q <= 16'h0000;
      rx_q <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      rd_q <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        tsr_pkg::TSR_H_IDLE: begin
          if (req) begin
            // RQ6: a write carries the pointer byte first
            st_q <= tsr_pkg::TSR_H_START;
            q_q <= 2'h0;
            rw_q <= rd_not_wr;
            addr_q <= slave_addr;
            ptr_q <= ptr_byte;
            wd_q <= wr_data;
            nack_q <= 1'b0;
            rd_q <= 16'h0000;
            nb_q <= rd_not_wr ? ((rd_len == 2'h2) ? 3'h3 : 3'h2) : 3'h2 + {1'b0, wr_len};
          end
        end
        tsr_pkg::TSR_H_START: begin
          if (tick) begin
            q_q <= q_q + 2'h1;
            // data falls while the clock is high, then clock falls
            if (q_q == 2'h0) begin
              sda_oe_q <= 1'b1;
            end
            if (q_q == 2'h2) begin
              scl_oe_q <= 1'b1;
            end
            if (q_q == 2'h3) begin
              st_q <= tsr_pkg::TSR_H_BIT;
              bit_q <= 4'h0;
              bi_q <= 3'h0;
            end
          end
        end
        tsr_pkg::TSR_H_BIT: begin
          if (tick) begin
            q_q <= q_q + 2'h1;
            case (q_q)
              2'h0: scl_oe_q <= 1'b1;
              2'h1: begin
                if (bit_q != 4'h8) begin
                  sda_oe_q <= tx_phase & ~tx_byte[3'(4'h7 - bit_q)];
                end else begin
                  // RQ10: ack every read byte but the last
                  sda_oe_q <= ~tx_phase & ~last;
                end
              end
              2'h2: scl_oe_q <= 1'b0;
              default: begin
                if (bit_q != 4'h8) begin
                  rx_q <= {rx_q[6:0], sda_s_q[1]};
                  bit_q <= bit_q + 4'h1;
                end else begin
                  bit_q <= 4'h0;
                  if (tx_phase && sda_s_q[1]) begin
                    nack_q <= 1'b1;
                    st_q <= tsr_pkg::TSR_H_STOP;
                  end else begin
                    if (!tx_phase) begin
                      rd_q <= {rd_q[7:0], rx_q};
                    end
                    // RQ4: every transfer ends with a stop
                    if (last) begin
                      st_q <= tsr_pkg::TSR_H_STOP;
                    end else begin
                      bi_q <= bi_q + 3'h1;
                    end
                  end
                end
              end
            endcase
          end
        end
        tsr_pkg::TSR_H_STOP: begin
          if (tick) begin
            q_q <= q_q + 2'h1;
            // clock low, data low, clock high, data high
            case (q_q)
              2'h0: scl_oe_q <= 1'b1;
              2'h1: sda_oe_q <= 1'b1;
              2'h2: scl_oe_q <= 1'b0;
              default: begin
                sda_oe_q <= 1'b0;
                done_q <= 1'b1;
                st_q <= tsr_pkg::TSR_H_IDLE;
              end
            endcase
          end
        end
        default: st_q <= tsr_pkg::TSR_H_IDLE;
      endcase
    end
  end

  // outputs
  assign link.scl_host_o = 1'b0;
  assign link.scl_host_oe = scl_oe_q;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe = sda_oe_q;
  assign busy = (st_q != tsr_pkg::TSR_H_IDLE);
  assign done = done_q;
  assign nacked = nack_q;
  assign rd_data = rd_q;
endmodule

/* tb/tsr_link_assertions.sv */
// link and reload checks for the sensor port
`timescale 1ns/1ps
module tsr_link_assertions (
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // link lines and drivers
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_host_oe,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  // reload status
  input wire logic reload_busy
);
  logic [11:0] rl_cnt_q; // cycles spent reloading
  // counts reload cycles so the length is checked without a long repeat
  always_ff @(posedge clk_sys) begin
    rl_cnt_q <= (rst || !reload_busy) ? 12'h000 : rl_cnt_q + 12'h001;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_lo; !scl [*8]; endsequence
  sequence s_hi; scl [*8]; endsequence
  property p_rst_quiet; disable iff (1'b0) rst |=> !scl_host_oe && !sda_host_oe && !sda_dev_oe; endproperty
  property p_dev_edge; $changed(sda_dev_oe) |-> !scl; endproperty
  property p_ack_hold; $rose(sda_dev_oe) |-> sda_dev_oe [*8]; endproperty
  property p_scl_lo; $fell(scl) |-> s_lo; endproperty
  property p_scl_hi; $rose(scl) |-> s_hi; endproperty
  property p_rl_len; $fell(reload_busy) |-> rl_cnt_q inside {12'h7d0, 12'h7d1}; endproperty
  property p_rl_quiet; reload_busy |-> !sda_dev_oe; endproperty
  property p_rl_stop; $rose(reload_busy) |-> scl && sda; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("driver active after reset");
  a_dev_edge: assert property (p_dev_edge) else $error("sensor data moved with clock high");
  a_ack_hold: assert property (p_ack_hold) else $error("sensor drive too short");
  a_scl_lo: assert property (p_scl_lo) else $error("clock low too short");
  a_scl_hi: assert property (p_scl_hi) else $error("clock high too short");
  a_rl_len: assert property (p_rl_len) else $error("reload length wrong");
  a_rl_quiet: assert property (p_rl_quiet) else $error("sensor drove during reload");
  a_rl_stop: assert property (p_rl_stop) else $error("reload began off a stop");
endmodule

/* tb/i2c_sensor_register_port_bench.sv */
// end to end bench for the sensor register port
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module i2c_sensor_register_port_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic rd_not_wr = 1'b0;
  logic [6:0] slave_addr = 7'h00;
  logic [7:0] ptr_byte = 8'h00;
  logic [1:0] wr_len = 2'h0;
  logic [1:0] rd_len = 2'h0;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] temp_value = 16'h1000; // inside both limits
  logic busy, done, nacked, alert_oe, alert_active, reload_busy;
  logic [15:0] rd_data;
  int num_errors = 0;
  int check_count = 0;
  always #50 clk_sys = ~clk_sys;
  tsr_link_if link ();
  tsr_host u_tsr_host (.clk_sys(clk_sys), .rst(rst), .link(link), .req(req), .rd_not_wr(rd_not_wr),
    .slave_addr(slave_addr), .ptr_byte(ptr_byte), .wr_len(wr_len), .wr_data(wr_data), .rd_len(rd_len),
    .busy(busy), .done(done), .nacked(nacked), .rd_data(rd_data));
  tsr_device u_tsr_device (.clk_sys(clk_sys), .rst(rst), .link(link), .addr_select_bit0(1'b0),
    .addr_select_bit1(1'b0), .temp_value(temp_value), .alert_o(), .alert_oe(alert_oe),
    .alert_active(alert_active), .reload_busy(reload_busy));
  tsr_link_assertions u_tsr_link_assertions (.clk_sys(clk_sys), .rst(rst), .scl(link.scl), .sda(link.sda),
    .scl_host_oe(link.scl_host_oe), .sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe),
    .reload_busy(reload_busy));
  // compare one value, counting checks and misses
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one transfer: request raised for one clock, then bounded wait for done
  task automatic xfer(input logic rd, input logic [6:0] sa, input logic [7:0] pb, input logic [1:0] wl,
      input logic [15:0] wd, input logic [1:0] rl);
    int n;
    @(negedge clk_sys);
    {rd_not_wr, slave_addr, ptr_byte, wr_len, wr_data, rd_len} = {rd, sa, pb, wl, wd, rl};
    req = 1'b1;
    @(negedge clk_sys);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 9000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 9000) chk("done", 16'h0001, 16'h0000);
  endtask
  task automatic wr(input logic [7:0] pb, input logic [1:0] wl, input logic [15:0] wd);
    xfer(1'b0, 7'h48, pb, wl, wd, 2'h0);
  endtask
  // pointer write, then read of one or two bytes
  task automatic rd(input logic [7:0] pb, input logic [1:0] rl);
    wr(pb, 2'h0, 16'h0000);
    xfer(1'b1, 7'h48, pb, 2'h0, 16'h0000, rl);
  endtask
  task automatic settle(input logic [15:0] t);
    temp_value = t;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    wr(8'h04, 2'h2, 16'h1234);
    rd(8'h04, 2'h2);
    chk("high limit", 16'h1234, rd_data);
    xfer(1'b1, 7'h48, 8'h00, 2'h0, 16'h0000, 2'h2);
    chk("pointer kept", 16'h1234, rd_data);
    wr(8'h0a, 2'h2, 16'h0799);
    rd(8'h0a, 2'h1);
    chk("surplus byte", 16'h0007, {8'h00, rd_data[7:0]});
    rd(8'h0b, 2'h2);
    chk("no sweep", {2{`TSR_RST_ID}}, rd_data);
    xfer(1'b0, 7'h4a, 8'h04, 2'h0, 16'h0000, 2'h0);
    chk("foreign address", 16'h0001, {15'h0, nacked});
    settle(16'h1300);
    chk("alert set", 16'h0003, {14'h0, alert_oe, alert_active});
    rd(8'h0b, 2'h1);
    chk("read clears", 16'h0000, {15'h0, alert_active});
    wr(8'h03, 2'h2, 16'h1010);
    settle(16'h1300);
    chk("comparator set", 16'h0001, {15'h0, alert_active});
    wr(8'h03, 2'h1, 16'h7000);
    settle(16'h1000);
    chk("inside hysteresis", 16'h0001, {15'h0, alert_active});
    settle(16'h0e00);
    chk("released", 16'h0000, {15'h0, alert_active});
    xfer(1'b0, 7'h00, 8'h05, 2'h0, 16'h0000, 2'h0);
    chk("other call", 16'h0001, {15'h0, nacked});
    xfer(1'b0, 7'h00, `TSR_GC_RESET, 2'h0, 16'h0000, 2'h0);
    chk("call reset", 16'h0000, {15'h0, nacked});
    repeat (`TSR_RELOAD_CYC) @(negedge clk_sys);
    rd(8'h0a, 2'h1);
    chk("call defaults", {8'h00, `TSR_RST_HYST}, {8'h00, rd_data[7:0]});
    wr(8'h04, 2'h2, 16'h1234);
    wr(`TSR_CMD_SOFT_RESET, 2'h0, 16'h0000);
    wr(8'h04, 2'h0, 16'h0000);
    chk("reload silent", 16'h0001, {15'h0, nacked});
    repeat (`TSR_RELOAD_CYC) @(negedge clk_sys);
    rd(8'h04, 2'h2);
    chk("reset defaults", `TSR_RST_HIGH, rd_data);
    test_done();
  end
  // hang guard, well past the expected run length
  initial begin
    repeat (90000) @(posedge clk_sys);
    chk("watchdog", 16'h0001, 16'h0000);
    test_done();
  end
endmodule
